// *** inc/store_pkg.sv ***
// Purpose: shared constants for the unaligned store address unit
// Assumes: 32-bit registers, two register files of 32 entries each
// Notes: circular-mode register layout and opcode tails are local choices
`default_nettype none
package store_pkg;
	localparam int        REG_W         = 32;
	localparam int        IDX_W         = 5;
	// opcode field positions
	localparam int        F_SRC_LSB     = 23;
	localparam int        F_DSRC_LSB    = 24;
	localparam int        F_SCALE_BIT   = 23;
	localparam int        F_BASE_LSB    = 18;
	localparam int        F_OFF_LSB     = 13;
	localparam int        F_MODE_LSB    = 9;
	localparam int        F_UNIT_BIT    = 7;
	localparam int        F_OP_LSB      = 2;
	localparam int        F_FILE_BIT    = 1;
	// bits 6..2 of the opcode
	localparam logic [4:0] OP_WORD      = 5'h15;
	localparam logic [4:0] OP_DWORD     = 5'h1d;
	// offset scaling
	localparam logic [1:0] SHIFT_WORD   = 2'h2;
	localparam logic [1:0] SHIFT_DWORD  = 2'h3;
	localparam logic [1:0] SHIFT_NONE   = 2'h0;
	// mode field bit meanings
	localparam int        M_ADD         = 0;
	localparam int        M_POST        = 1;
	localparam int        M_REGOFF      = 2;
	localparam int        M_MODIFY      = 3;
	// circular-mode control layout
	localparam int        AM_FIELD_W    = 2;
	localparam int        AM_B_LSB      = 8;
	localparam int        AM_BLK0_LSB   = 16;
	localparam int        AM_BLK1_LSB   = 21;
	localparam int        AM_BLK_W      = 5;
	localparam logic [1:0] AM_CIRC0     = 2'h1;
	localparam logic [1:0] AM_CIRC1     = 2'h2;
	localparam logic [IDX_W-1:0] CIRC_LO = 5'h04;
	localparam logic [IDX_W-1:0] CIRC_HI = 5'h07;
	// bytes per store
	localparam logic [3:0] BYTES_WORD   = 4'h4;
	localparam logic [3:0] BYTES_DWORD  = 4'h8;
	// values after reset
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
endpackage
`default_nettype wire

// *** inc/agen_if.sv ***
// Purpose: carries one address request and its result to the address generator
// Assumes: purely combinational generator on the same clock
// Notes: none
`default_nettype none
interface agen_if;
	logic [31:0] base;
	logic [4:0]  offset;
	logic [3:0]  mode;
	logic [1:0]  shift;
	logic        circ;
	logic [4:0]  blk;
	logic [31:0] addr;
	logic [31:0] new_base;
	logic        writes_base;
	modport issuer (output base, offset, mode, shift, circ, blk,
		input addr, new_base, writes_base);
	modport gen (input base, offset, mode, shift, circ, blk,
		output addr, new_base, writes_base);
endinterface
`default_nettype wire

// *** hdl/addr_gen.sv ***
// Purpose: effective address and updated base for one store
// Assumes: offset already chosen between register and short constant
// Notes: combinational, no state
`default_nettype none
module addr_gen (
	agen_if.gen a
);
	logic [31:0] scaled;
	logic [31:0] sum;
	logic [31:0] mask;
	logic [31:0] result;

	always_comb begin
		// R4 R11 offset scaling
		scaled = {27'h0, a.offset} << a.shift;
		sum = a.mode[store_pkg::M_ADD] ? a.base + scaled : a.base - scaled;
		// block of 2^(n+1) bytes; top bits of base stay put in circular mode
		mask = 32'hffff_ffff >> (5'h1f - a.blk);
		// R6 linear or circular
		result = a.circ ? ((a.base & ~mask) | (sum & mask)) : sum;
		// R5 post modes use the old base
		a.addr = (a.mode[store_pkg::M_MODIFY] && a.mode[store_pkg::M_POST]) ? a.base : result;
		a.new_base = result;
		a.writes_base = a.mode[store_pkg::M_MODIFY];
	end
endmodule // addr_gen
`default_nettype wire

// *** hdl/nonaligned_store_address_unit.sv ***
// Purpose: issues unaligned word and double-word stores for one data unit pair
// Assumes: register file answers reads in the same cycle; predicate resolved outside
// Notes: results registered, visible one cycle after issue
// Notes on behaviour
// R1: word store writes 32 bits anywhere
// R2: address is base plus register or constant
// R3: unit bit picks unit and base file
// R4: word offset shifted left by two
// R5: post modes access unmodified base
// R6: linear default, circular for indices 4..7
// R7: file bit picks source register file
// R8: four-bit mode field decoding table
// R9: no other memory access alongside
// R10: double-word store writes 64 bits anywhere
// R11: scale flag shifts double-word offset three
// R12: bytes stored little-endian, ascending addresses
// R13: false predicate does nothing; base written E1
`default_nettype none
module nonaligned_store_address_unit #(
	// register and index widths; the opcode layout only serves the defaults
	parameter int REG_W = store_pkg::REG_W,
	parameter int IDX_W = store_pkg::IDX_W
) (
	// clock and control
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	// instruction issue
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr,
	input  wire logic        pred_true,
	input  wire logic [31:0] addressing_mode_reg,
	// register file read ports
	output logic             base_rd_file,
	output logic [4:0]       base_rd_idx,
	output logic [4:0]       off_rd_idx,
	output logic             src_rd_file,
	output logic [4:0]       src_rd_idx_lo,
	output logic [4:0]       src_rd_idx_hi,
	input  wire logic [31:0] base_pointer_reg,
	input  wire logic [31:0] offset_index_reg,
	input  wire logic [31:0] src_lo,
	input  wire logic [31:0] src_hi,
	// memory write request
	output logic             mem_wr,
	output logic [31:0]      mem_addr,
	output logic [3:0]       mem_bytes,
	output logic [63:0]      mem_wdata,
	output logic [31:0]      mem_line_addr,
	output logic [15:0]      mem_lane_en,
	output logic [127:0]     mem_lane_data,
	output logic             unit_two_busy,
	// base write-back
	output logic             wb_en,
	output logic             wb_file,
	output logic [4:0]       wb_idx,
	output logic [31:0]      wb_data,
	// decode errors
	output logic             bad_mode
);
	// everything registered lives here; clk_en low freezes all of it, but nrst low still clears it
	typedef struct packed {
		logic         mem_wr;
		logic [31:0]  mem_addr;
		logic [3:0]   mem_bytes;
		logic [63:0]  mem_wdata;
		logic [31:0]  line_addr;
		logic [15:0]  lane_en;
		logic [127:0] lane_data;
		logic         unit_two;
		logic         wb_en;
		logic         wb_file;
		logic [4:0]   wb_idx;
		logic [31:0]  wb_data;
		logic         bad_mode;
	} state_t;

	state_t st;
	state_t next_st;

	agen_if ag ();

	addr_gen u_agen (
		.a (ag)
	);

	// opcode fields and the pair packing are fixed at these widths
	if (REG_W != 32) begin : g_reg_w_check
		$error("register width must be 32");
	end
	if (IDX_W != 5) begin : g_idx_w_check
		$error("register index width must be 5");
	end
	// the low two index bits pick the mode field, so 4..7 must be one aligned group
	localparam bit CIRC_ALIGNED = store_pkg::CIRC_LO[1:0] == 2'h0
		&& store_pkg::CIRC_HI == store_pkg::CIRC_LO + 5'h03;
	if (!CIRC_ALIGNED) begin : g_circ_check
		$error("circular base indices must be one aligned group of four");
	end
	// both files' mode fields must sit below the block size fields
	localparam int AM_TOP = store_pkg::AM_B_LSB + 4 * store_pkg::AM_FIELD_W;
	if (AM_TOP > store_pkg::AM_BLK0_LSB) begin : g_am_check
		$error("circular mode control fields overlap");
	end

	// decode of the presented opcode
	logic       is_word;
	logic       is_dword;
	logic [3:0] mode;
	logic       mode_ok;
	logic       unit;
	logic [4:0] base_idx;
	logic [1:0] am_field;
	// source value as it goes to memory
	logic [63:0] data;

	// legal codes: 0x0x, 1x0x, 1x1x; 0x1x, post without modify, is rejected
	function automatic logic legal_mode(input logic [3:0] m);
		legal_mode = m[store_pkg::M_MODIFY] || !m[store_pkg::M_POST];
	endfunction

	// one register index or short constant out of the opcode
	function automatic logic [store_pkg::IDX_W-1:0] field5(input logic [31:0] w, input int lsb);
		field5 = w[lsb +: store_pkg::IDX_W];
	endfunction

	// byte lanes of one store, low byte in the lowest lane
	function automatic logic [15:0] lane_mask(input logic dword, input logic [2:0] lo);
		lane_mask = (dword ? 16'h00ff : 16'h000f) << lo;
	endfunction

	always_comb begin
		is_word  = instr[store_pkg::F_OP_LSB +: 5] == store_pkg::OP_WORD;
		is_dword = instr[store_pkg::F_OP_LSB +: 5] == store_pkg::OP_DWORD;
		mode     = instr[store_pkg::F_MODE_LSB +: 4];
		// R8 mode field decode
		mode_ok  = legal_mode(mode);
		// R3 unit selects base and offset file
		unit     = instr[store_pkg::F_UNIT_BIT];
		base_idx = field5(instr, store_pkg::F_BASE_LSB);
		base_rd_file = unit;
		base_rd_idx  = base_idx;
		off_rd_idx   = field5(instr, store_pkg::F_OFF_LSB);
		// R7 source file independent of unit
		src_rd_file  = instr[store_pkg::F_FILE_BIT];
		src_rd_idx_lo = is_dword ? {instr[store_pkg::F_DSRC_LSB +: 4], 1'b0}
			: instr[store_pkg::F_SRC_LSB +: 5];
		src_rd_idx_hi = {instr[store_pkg::F_DSRC_LSB +: 4], 1'b1};
	end

	always_comb begin
		// R2 register or short unsigned constant offset
		ag.base   = base_pointer_reg;
		ag.offset = mode[store_pkg::M_REGOFF] ? offset_index_reg[4:0]
			: field5(instr, store_pkg::F_OFF_LSB);
		ag.mode   = mode;
		// R4 word scale; R11 double-word scale flag
		ag.shift  = is_dword ? (instr[store_pkg::F_SCALE_BIT] ? store_pkg::SHIFT_DWORD
			: store_pkg::SHIFT_NONE) : store_pkg::SHIFT_WORD;
		// R6 circular only for indices 4..7
		am_field = addressing_mode_reg[(unit ? store_pkg::AM_B_LSB : 0)
			+ store_pkg::AM_FIELD_W * (base_idx[1:0]) +: store_pkg::AM_FIELD_W];
		ag.circ = base_idx >= store_pkg::CIRC_LO && base_idx <= store_pkg::CIRC_HI
			&& (am_field == store_pkg::AM_CIRC0 || am_field == store_pkg::AM_CIRC1);
		ag.blk = (am_field == store_pkg::AM_CIRC1)
			? addressing_mode_reg[store_pkg::AM_BLK1_LSB +: store_pkg::AM_BLK_W]
			: addressing_mode_reg[store_pkg::AM_BLK0_LSB +: store_pkg::AM_BLK_W];
	end

	always_comb begin
		// R1 R10 full source value, upper word only for double-word
		data = is_dword ? {src_hi, src_lo} : {32'h0, src_lo};
		next_st = st;
		next_st.mem_wr = 1'b0;
		next_st.wb_en = 1'b0;
		next_st.bad_mode = 1'b0;
		// R13 false predicate: no store, no write-back
		if (instr_valid && pred_true && (is_word || is_dword)) begin
			if (!mode_ok) begin
				next_st.bad_mode = 1'b1;
			end else begin
				next_st.mem_wr    = 1'b1;
				next_st.mem_addr  = ag.addr;
				next_st.mem_bytes = is_dword ? store_pkg::BYTES_DWORD : store_pkg::BYTES_WORD;
				next_st.mem_wdata = data;
				// R12 low byte at lowest address, lanes shifted by misalignment
				next_st.line_addr = {ag.addr[31:3], 3'h0};
				next_st.lane_en   = lane_mask(is_dword, ag.addr[2:0]);
				next_st.lane_data = {64'h0, data} << {ag.addr[2:0], 3'h0};
				// R9 one memory access only; report unit for scheduling
				next_st.unit_two  = unit;
				// R13 base written back in the same stage
				next_st.wb_en   = ag.writes_base;
				next_st.wb_file = unit;
				next_st.wb_idx  = base_idx;
				next_st.wb_data = ag.new_base;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// outputs straight from the register copy
	always_comb begin
		mem_wr        = st.mem_wr;
		mem_addr      = st.mem_addr;
		mem_bytes     = st.mem_bytes;
		mem_wdata     = st.mem_wdata;
		mem_line_addr = st.line_addr;
		mem_lane_en   = st.lane_en;
		mem_lane_data = st.lane_data;
		unit_two_busy = st.unit_two;
		wb_en         = st.wb_en;
		wb_file       = st.wb_file;
		wb_idx        = st.wb_idx;
		wb_data       = st.wb_data;
		bad_mode      = st.bad_mode;
	end
endmodule // nonaligned_store_address_unit
`default_nettype wire

// *** tb/store_mem_model.sv ***
// Purpose: byte memory behind the store port
// Assumes: only the low 8 address bits matter
// Notes: one write per store pulse
`default_nettype none
module store_mem_model (
	// store port
	input  wire logic        core_clk,
	input  wire logic        mem_wr,
	input  wire logic [31:0] mem_addr,
	input  wire logic [3:0]  mem_bytes,
	input  wire logic [63:0] mem_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:255] = '{default: 8'h00};
	always @(posedge core_clk) begin
		if (mem_wr) begin
			for (int k = 0; k < int'(mem_bytes); k++) begin
				mem[8'(mem_addr[7:0] + k)] <= mem_wdata[8*k +: 8];
			end
		end
	end
endmodule // store_mem_model
`default_nettype wire

// *** tb/nonaligned_store_address_unit_checker.sv ***
// Purpose: port-level checks of the store unit
// Assumes: addresses and write-back are checked in linear mode only
// Notes: bound to the top module
`default_nettype none
module nonaligned_store_address_unit_checker (
	// clock and issue
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        clk_en,
	input wire logic        instr_valid,
	input wire logic [31:0] instr,
	input wire logic        pred_true,
	input wire logic [31:0] addressing_mode_reg,
	input wire logic [31:0] base_pointer_reg,
	input wire logic [31:0] offset_index_reg,
	// results
	input wire logic        base_rd_file,
	input wire logic        src_rd_file,
	input wire logic        mem_wr,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0]  mem_bytes,
	input wire logic        wb_en,
	input wire logic [31:0] wb_data,
	input wire logic        bad_mode
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire       tk = clk_en && instr_valid && pred_true;
	wire [3:0] md = instr[12:9];
	wire       ok = md[3] || !md[1];
	wire       st = instr[6:2] == store_pkg::OP_WORD || instr[6:2] == store_pkg::OP_DWORD;
	wire       wd = tk && ok && instr[6:2] == store_pkg::OP_WORD && addressing_mode_reg == 0;
	wire [31:0] sh = {27'h0, md[2] ? offset_index_reg[4:0] : instr[17:13]} << 2;
	wire [31:0] ea = md[0] ? base_pointer_reg + sh : base_pointer_reg - sh;
	property p_word; wd |=> mem_wr && mem_bytes == 4'h4 && wb_en == $past(md[3]); endproperty
	a_word: assert property (p_word) else $error("word store pulse wrong");
	property p_dword; tk && ok && instr[6:2] == store_pkg::OP_DWORD |-> ##1 mem_bytes == 4'h8;
	endproperty
	a_dword: assert property (p_dword) else $error("dword size wrong");
	property p_addr; wd && !md[1] |=> mem_addr == $past(ea); endproperty
	a_addr: assert property (p_addr) else $error("address wrong");
	property p_post; wd && md[1] |=> mem_addr == $past(base_pointer_reg); endproperty
	a_post: assert property (p_post) else $error("post address wrong");
	property p_wb; wd && md[3] |=> wb_data == $past(ea); endproperty
	a_wb: assert property (p_wb) else $error("write-back wrong");
	property p_bad; tk && st && !ok |=> bad_mode && !mem_wr && !wb_en; endproperty
	a_bad: assert property (p_bad) else $error("illegal mode accepted");
	property p_pred; clk_en && instr_valid && !pred_true |=> !mem_wr && !wb_en; endproperty
	a_pred: assert property (p_pred) else $error("false predicate stored");
	property p_unit; instr_valid |-> base_rd_file == instr[7]; endproperty
	a_unit: assert property (p_unit) else $error("base file wrong");
	property p_src; instr_valid |-> src_rd_file == instr[1]; endproperty
	a_src: assert property (p_src) else $error("source file wrong");
	c_post: cover property (wd && md[1]);
	c_bad: cover property (tk && st && !ok);
	c_dw: cover property (tk && instr[6:2] == store_pkg::OP_DWORD);
	c_circ: cover property (tk && st && ok && addressing_mode_reg != 32'h0);
endmodule // nonaligned_store_address_unit_checker
bind nonaligned_store_address_unit nonaligned_store_address_unit_checker u_chk (.core_clk,
	.nrst, .clk_en, .instr_valid, .instr, .pred_true, .addressing_mode_reg, .base_pointer_reg,
	.offset_index_reg, .base_rd_file, .src_rd_file, .mem_wr, .mem_addr, .mem_bytes, .wb_en,
	.wb_data, .bad_mode);
`default_nettype wire

// *** tb/nonaligned_store_address_unit_bench.sv ***
// Purpose: directed stores through every mode code
// Assumes: linear mode except one circular store; clock enable low for the last store
// Notes: memory contents read from the model
`default_nettype none
module nonaligned_store_address_unit_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, nrst, clk_en, instr_valid, pred_true, base_rd_file, src_rd_file;
	logic mem_wr, wb_en, bad_mode, unit_two_busy, wb_file;
	logic [4:0]  base_rd_idx, off_rd_idx, src_rd_idx_lo, src_rd_idx_hi, wb_idx;
	logic [15:0] mem_lane_en;
	logic [127:0] mem_lane_data;
	logic [31:0] instr, addressing_mode_reg, base_pointer_reg, offset_index_reg;
	logic [31:0] src_lo, src_hi, mem_addr, wb_data, ea, mem_line_addr;
	logic [3:0]  mem_bytes, md;
	logic [63:0] mem_wdata, got;
	int fails = 0;
	int n_checks = 0;
	nonaligned_store_address_unit u_dut (.core_clk, .nrst, .clk_en, .instr_valid, .instr,
		.pred_true, .addressing_mode_reg, .base_rd_file, .base_rd_idx, .off_rd_idx,
		.src_rd_file, .src_rd_idx_lo, .src_rd_idx_hi, .base_pointer_reg, .offset_index_reg,
		.src_lo, .src_hi, .mem_wr, .mem_addr, .mem_bytes, .mem_wdata, .mem_line_addr,
		.mem_lane_en, .mem_lane_data, .unit_two_busy, .wb_en, .wb_file, .wb_idx,
		.wb_data, .bad_mode);
	store_mem_model m (.core_clk, .mem_wr, .mem_addr, .mem_bytes, .mem_wdata);
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	function logic [31:0] mk(logic [4:0] op, logic [3:0] m4, logic [4:0] hi, logic y, logic s);
		return {4'h0, hi, 5'h01, 5'h02, m4, 1'b0, y, op, s, 1'b0};
	endfunction
	// one store alone in its packet, answer one cycle later
	task go(input logic [31:0] in, input logic p, input logic [2:0] ef, input logic [31:0] eadr,
		input logic [31:0] ewb);
		logic dw;
		dw = in[6:2] == store_pkg::OP_DWORD;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr <= in;
		pred_true <= p;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1;
		chk(base_rd_file, in[7]);
		chk(base_rd_idx, in[22:18]);
		chk(off_rd_idx, in[17:13]);
		chk(src_rd_file, in[1]);
		chk(src_rd_idx_lo, dw ? {in[27:24], 1'b0} : in[27:23]);
		if (dw) chk(src_rd_idx_hi, {in[27:24], 1'b1});
		chk({mem_wr, wb_en, bad_mode}, ef);
		if (ef[2]) begin
			chk(mem_addr, eadr);
			chk(mem_line_addr, {eadr[31:3], 3'h0});
			chk(mem_lane_en, (dw ? 16'h00ff : 16'h000f) << eadr[2:0]);
			chk(mem_lane_data[8*eadr[2:0] +: 32], src_lo);
			if (dw) chk(mem_lane_data[8*eadr[2:0]+32 +: 32], src_hi);
			chk(unit_two_busy, in[7]);
		end
		if (ef[1]) begin
			chk(wb_data, ewb);
			chk(wb_file, in[7]);
			chk(wb_idx, in[22:18]);
		end
	endtask
	task mchk(input logic [63:0] exp);
		@(posedge core_clk);
		#1;
		for (int k = 0; k < 8; k++) got[8*k +: 8] = m.mem[8'(8'h03 + k)];
		chk(got, exp);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		#100us;
		fails++;
		summarize;
	end
	initial begin
		{nrst, instr_valid, pred_true, instr, addressing_mode_reg} = '0;
		clk_en = 1'b1;
		base_pointer_reg = 32'h1001;
		offset_index_reg = 32'h3;
		src_lo = 32'ha1763b28;
		src_hi = 32'h0;
		repeat (8) @(posedge core_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			md = i[3:0];
			ea = md[0] ? 32'h1001 + (md[2] ? 32'hc : 32'h8) : 32'h1001 - (md[2] ? 32'hc : 32'h8);
			go(mk(store_pkg::OP_WORD, md, 5'h0, i[4], !i[4]), 1'b1,
				(!md[3] && md[1]) ? 3'b001 : {1'b1, md[3], 1'b0}, md[1] ? 32'h1001 : ea, ea);
		end
		mchk(64'h3b28_0000_0000_a176);
		@(posedge core_clk);
		base_pointer_reg <= 32'h1003;
		src_lo <= 32'h6041ad65;
		src_hi <= 32'ha1763b28;
		go(mk(store_pkg::OP_DWORD, 4'hf, 5'h01, 1'b0, 1'b1), 1'b1, 3'b110, 32'h1003, 32'h101b);
		mchk(64'ha1763b28_6041ad65);
		go(mk(store_pkg::OP_DWORD, 4'h1, 5'h00, 1'b1, 1'b0), 1'b1, 3'b100, 32'h1005, 32'h0);
		go(mk(store_pkg::OP_WORD, 4'hf, 5'h0, 1'b0, 1'b0), 1'b0, 3'b000, 32'h0, 32'h0);
		go(mk(5'h00, 4'hf, 5'h0, 1'b1, 1'b1), 1'b1, 3'b000, 32'h0, 32'h0);
		// 16-byte block at base index 5, pre-increment wraps inside it
		@(posedge core_clk);
		base_pointer_reg <= 32'h100e;
		addressing_mode_reg <= 32'h0003_0004;
		go(mk(store_pkg::OP_WORD, 4'hd, 5'h0, 1'b0, 1'b0) | 32'h0010_0000, 1'b1, 3'b110,
			32'h100a, 32'h100a);
		// clock enable low: a store presented then is not taken
		@(posedge core_clk);
		clk_en <= 1'b0;
		go(mk(store_pkg::OP_WORD, 4'hf, 5'h0, 1'b0, 1'b0), 1'b1, 3'b000, 32'h0, 32'h0);
		@(posedge core_clk);
		clk_en <= 1'b1;
		summarize;
	end
endmodule // nonaligned_store_address_unit_bench
`default_nettype wire
